//--- inc/flash_cfg_consts.vh
`ifndef FLASH_CFG_CONSTS_VH
`define FLASH_CFG_CONSTS_VH

// Command opcodes
`define OP_WRITE_REGS 8'h01
`define OP_READ_CONFIG 8'h35
`define OP_READ_ANY 8'h65
`define OP_WRITE_ANY 8'h71

// Register addresses used by the any-register commands
`define ADDR_STATUS_ONE_NV 24'h000000
`define ADDR_CONFIG_ONE_NV 24'h000002
`define ADDR_STATUS_ONE_V 24'h800000
`define ADDR_CONFIG_ONE_V 24'h800002

// Status register field positions
`define SR_WRITE_DISABLE 7
`define SR_PROGRAM_ERROR 6
`define SR_PROTECT_HI 4
`define SR_PROTECT_LO 2
`define SR_BUSY 0

// Configuration register one field positions
`define CR_PROTECT_START 5
`define CR_PROTECT_SOURCE 3
`define CR_PARAM_LOCATION 2
`define CR_FOUR_LANE 1
`define CR_LOCK 0

// Reset values
`define PROTECT_FORCED 3'h7
`define PROTECT_SHIPPED 3'h0
`define LOCK_DEFAULT 1'h0
`define PIN_RESET 6'h2C

// Non-volatile write time and core clock rate
`define NV_WRITE_TIME_US 100
`define CORE_CLK_MHZ 50

`endif

//--- core/pin_sync.v
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
	parameter WIDTH = 6,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire core_clk,
	input wire reset_n,
	// Asynchronous pins in, synchronous copies out
	input wire [WIDTH-1:0] pin_in,
	output reg [WIDTH-1:0] pin_out
);

	reg [WIDTH-1:0] stage_one;

	// Two flip-flops; the first is read only by the second
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage_one <= RESET_VALUE;
			pin_out <= RESET_VALUE;
		end else begin
			stage_one <= pin_in;
			pin_out <= stage_one;
		end
	end

endmodule // pin_sync

`default_nettype wire

//--- core/flash_config_protection_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "flash_cfg_consts.vh"

module flash_config_protection_regs #(
	parameter NV_WRITE_CYCLES = `NV_WRITE_TIME_US * `CORE_CLK_MHZ,
	parameter [7:0] OP_ONE_TIME_PROGRAM = 8'h42,
	parameter [7:0] OP_SOFT_RESET = 8'hF0,
	parameter [23:0] ONE_TIME_FIRST = 24'h000000,
	parameter [23:0] ONE_TIME_LAST = 24'h0003FF
) (
	// Clock and reset
	input wire core_clk,
	input wire reset_n,
	// Serial link pins
	input wire sck,
	input wire cs_n,
	input wire [3:0] io_in,
	output reg [3:0] io_out,
	output reg [3:0] io_oe,
	// Neighbouring configuration logic
	input wire four_lane_instruction_protocol,
	input wire four_lane_protocol_nv_program,
	input wire lane3_reset_enable,
	input wire uniform_sectors,
	// Protection and mode state
	output reg [2:0] active_protect_range,
	output reg protect_from_bottom,
	output reg param_block_at_top,
	output reg four_lane_data,
	output reg four_lane_instructions,
	output reg write_protect_active,
	output reg lock_active,
	output reg program_error,
	output reg nv_write_busy,
	output reg one_time_program_start
);

	localparam ST_CMD = 5'h01;
	localparam ST_ADDR = 5'h02;
	localparam ST_DATA_IN = 5'h04;
	localparam ST_DATA_OUT = 5'h08;
	localparam ST_IGNORE = 5'h10;

	// Option bit write: sets may stick, clears never happen, lock blocks all
	function otp_write;
		input old_bit;
		input new_bit;
		input locked;
		begin
			otp_write = locked ? old_bit : (old_bit | new_bit);
		end
	endfunction

	// Four-lane width write: a clear is refused under the four-lane protocol
	function lane_write;
		input new_bit;
		input protocol_on;
		begin
			lane_write = new_bit | protocol_on;
		end
	endfunction

	wire [5:0] pins;
	wire cs_s = pins[5];
	wire sck_s = pins[4];
	wire [3:0] io_s = pins[3:0];

	pin_sync #(.WIDTH(6), .RESET_VALUE(`PIN_RESET)) u_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.pin_in({cs_n, sck, io_in}),
		.pin_out(pins)
	);

	// Configuration and status storage
	reg status_write_disable_default;
	reg [2:0] protect_range_nonvolatile;
	reg [2:0] protect_range_volatile;
	reg p_err;
	reg protect_start_otp;
	reg protection_source_select_otp;
	reg param_location_otp;
	reg four_lane_width_default;
	reg four_lane_width;
	reg lock;
	reg [23:0] busy_cnt;

	// Link state
	reg [4:0] state;
	reg sck_prev;
	reg cs_prev;
	reg qpi_frame;
	reg [7:0] opcode;
	reg [7:0] rx;
	reg [3:0] bit_cnt;
	reg [1:0] addr_bytes;
	reg [1:0] data_bytes;
	reg [23:0] addr;
	reg [7:0] data_first;
	reg [7:0] data_second;
	reg [7:0] tx;
	reg [7:0] tx_value;

	wire busy = busy_cnt != 24'h000000;
	wire sck_rise = sck_s & ~sck_prev;
	wire sck_fall = ~sck_s & sck_prev;
	wire frame_end = cs_s & ~cs_prev;
	wire [7:0] rx_next = qpi_frame ? {rx[3:0], io_s} : {rx[6:0], io_s[0]};
	wire [3:0] cnt_next = bit_cnt + (qpi_frame ? 4'h4 : 4'h1);
	wire byte_done = sck_rise & ~cs_s & (cnt_next == 4'h8);
	wire wp_low = ~four_lane_width & ~io_s[2];
	wire hw_reset = lane3_reset_enable & ~io_s[3] & (cs_s | ~four_lane_width);
	wire sw_reset = frame_end & state[0] == 1'b0 & opcode == OP_SOFT_RESET;
	// A frame cut inside its opcode must not replay the last write's data
	wire wr_ok = frame_end & ~busy & ~state[0] & data_bytes != 2'h0;
	wire status_blocked = status_write_disable_default & wp_low;
	wire do_wrr = wr_ok & opcode == `OP_WRITE_REGS & ~status_blocked;
	wire do_write_any_register_cmd = wr_ok & opcode == `OP_WRITE_ANY & addr_bytes == 2'h3;
	wire do_one_time_area_program_cmd = frame_end & opcode == OP_ONE_TIME_PROGRAM & addr_bytes == 2'h3 & ~state[0];
	wire in_otp = addr >= ONE_TIME_FIRST && addr <= ONE_TIME_LAST;
	wire bp_sel = protection_source_select_otp;
	wire [7:0] cr_nv = {2'h0, protect_start_otp, 1'b0, protection_source_select_otp, param_location_otp,
		four_lane_width_default, `LOCK_DEFAULT};
	wire [7:0] cr_v = {2'h0, protect_start_otp, 1'b0, protection_source_select_otp, param_location_otp,
		four_lane_width, lock};
	wire [7:0] sr_nv = {status_write_disable_default, 2'h0, protect_range_nonvolatile, 2'h0};
	wire [7:0] sr_v = {status_write_disable_default, p_err, 1'b0, protect_range_volatile, 1'b0, busy};

	// Read mux for the any-register read
	always @* begin
		if (addr == `ADDR_STATUS_ONE_NV) begin
			tx_value = sr_nv;
		end else if (addr == `ADDR_CONFIG_ONE_NV) begin
			tx_value = cr_nv;
		end else if (addr == `ADDR_STATUS_ONE_V) begin
			tx_value = sr_v;
		end else if (addr == `ADDR_CONFIG_ONE_V) begin
			tx_value = cr_v;
		end else begin
			tx_value = 8'h00;
		end
	end

	// Frame decoder: opcode, address, write data and read data
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_CMD;
			sck_prev <= 1'b0;
			cs_prev <= 1'b1;
			qpi_frame <= 1'b0;
			opcode <= 8'h00;
			rx <= 8'h00;
			bit_cnt <= 4'h0;
			addr_bytes <= 2'h0;
			data_bytes <= 2'h0;
			addr <= 24'h000000;
			data_first <= 8'h00;
			data_second <= 8'h00;
			tx <= 8'h00;
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end else begin
			sck_prev <= sck_s;
			cs_prev <= cs_s;
			if (cs_s) begin
				state <= ST_CMD;
				bit_cnt <= 4'h0;
				qpi_frame <= four_lane_instruction_protocol;
				io_oe <= 4'h0;
			end else begin
				if (sck_rise) begin
					rx <= rx_next;
					bit_cnt <= byte_done ? 4'h0 : cnt_next;
				end
				if (byte_done) begin
					case (state)
					ST_CMD: begin
						opcode <= rx_next;
						addr_bytes <= 2'h0;
						data_bytes <= 2'h0;
						if (rx_next == `OP_WRITE_REGS) begin
							state <= ST_DATA_IN;
						end else if (rx_next == `OP_READ_CONFIG) begin
							state <= ST_DATA_OUT;
							tx <= cr_v;
						end else if (rx_next == `OP_READ_ANY || rx_next == `OP_WRITE_ANY ||
							rx_next == OP_ONE_TIME_PROGRAM) begin
							state <= ST_ADDR;
						end else begin
							state <= ST_IGNORE;
						end
					end
					ST_ADDR: begin
						addr <= {addr[15:0], rx_next};
						addr_bytes <= addr_bytes + 2'h1;
						if (addr_bytes == 2'h2) begin
							if (opcode == `OP_READ_ANY) begin
								state <= ST_DATA_OUT;
							end else begin
								state <= ST_DATA_IN;
							end
						end
					end
					ST_DATA_IN: begin
						if (data_bytes == 2'h0) begin
							data_first <= rx_next;
						end else if (data_bytes == 2'h1) begin
							data_second <= rx_next;
						end
						if (data_bytes != 2'h2) begin
							data_bytes <= data_bytes + 2'h1;
						end
					end
					default: begin
						state <= state;
					end
					endcase
				end
				// Read data shifts out on falling edges, the same byte repeating
				if (state == ST_DATA_OUT && sck_fall) begin
					if (qpi_frame) begin
						io_out <= tx[7:4];
						io_oe <= 4'hF;
						tx <= {tx[3:0], tx[7:4]};
					end else begin
						io_out <= {2'h0, tx[7], 1'b0};
						io_oe <= 4'h2;
						tx <= {tx[6:0], tx[7]};
					end
				end else if (state == ST_ADDR && byte_done && addr_bytes == 2'h2) begin
					tx <= (opcode == `OP_READ_ANY) ? 8'h00 : tx;
				end else if (state == ST_DATA_OUT && opcode == `OP_READ_ANY && bit_cnt == 4'h0 &&
					io_oe == 4'h0) begin
					tx <= tx_value;
				end
			end
		end
	end

	// Register updates at frame end, resets, busy timer
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_write_disable_default <= 1'b0;
			protect_range_nonvolatile <= `PROTECT_SHIPPED;
			protect_range_volatile <= `PROTECT_FORCED;
			p_err <= 1'b0;
			protect_start_otp <= 1'b0;
			protection_source_select_otp <= 1'b0;
			param_location_otp <= 1'b0;
			four_lane_width_default <= 1'b0;
			four_lane_width <= 1'b0;
			lock <= `LOCK_DEFAULT;
			busy_cnt <= 24'h000000;
			one_time_program_start <= 1'b0;
		end else begin
			one_time_program_start <= 1'b0;
			if (busy) begin
				busy_cnt <= busy_cnt - 24'h000001;
			end
			if (hw_reset) begin
				protect_range_volatile <= `PROTECT_FORCED;
				four_lane_width <= four_lane_width_default;
				lock <= `LOCK_DEFAULT;
				p_err <= 1'b0;
			end else if (sw_reset) begin
				protect_range_volatile <= `PROTECT_FORCED;
				four_lane_width <= four_lane_width_default;
				p_err <= 1'b0;
			end else if (do_wrr) begin
				busy_cnt <= NV_WRITE_CYCLES[23:0];
				status_write_disable_default <= data_first[`SR_WRITE_DISABLE];
				if (!lock && !bp_sel) begin
					protect_range_nonvolatile <= data_first[`SR_PROTECT_HI:`SR_PROTECT_LO];
				end else if (!lock) begin
					protect_range_volatile <= data_first[`SR_PROTECT_HI:`SR_PROTECT_LO];
				end
				if (data_bytes == 2'h2) begin
					protect_start_otp <= otp_write(protect_start_otp, data_second[`CR_PROTECT_START], lock);
					protection_source_select_otp <= otp_write(protection_source_select_otp,
						data_second[`CR_PROTECT_SOURCE], lock);
					param_location_otp <= otp_write(param_location_otp, data_second[`CR_PARAM_LOCATION], lock);
					four_lane_width_default <= lane_write(data_second[`CR_FOUR_LANE],
						four_lane_instruction_protocol);
					four_lane_width <= lane_write(data_second[`CR_FOUR_LANE], four_lane_instruction_protocol);
					lock <= lock | data_second[`CR_LOCK];
				end
			end else if (do_write_any_register_cmd) begin
				if (addr == `ADDR_STATUS_ONE_NV) begin
					busy_cnt <= NV_WRITE_CYCLES[23:0];
					status_write_disable_default <= data_first[`SR_WRITE_DISABLE];
					if (!lock) begin
						protect_range_nonvolatile <= data_first[`SR_PROTECT_HI:`SR_PROTECT_LO];
					end
				end else if (addr == `ADDR_STATUS_ONE_V) begin
					if (!lock) begin
						protect_range_volatile <= data_first[`SR_PROTECT_HI:`SR_PROTECT_LO];
					end
				end else if (addr == `ADDR_CONFIG_ONE_NV) begin
					busy_cnt <= NV_WRITE_CYCLES[23:0];
					protect_start_otp <= otp_write(protect_start_otp, data_first[`CR_PROTECT_START], lock);
					protection_source_select_otp <= otp_write(protection_source_select_otp,
						data_first[`CR_PROTECT_SOURCE], lock);
					param_location_otp <= otp_write(param_location_otp, data_first[`CR_PARAM_LOCATION], lock);
					four_lane_width_default <= lane_write(data_first[`CR_FOUR_LANE],
						four_lane_instruction_protocol);
				end else if (addr == `ADDR_CONFIG_ONE_V) begin
					four_lane_width <= lane_write(data_first[`CR_FOUR_LANE], four_lane_instruction_protocol);
					lock <= lock | data_first[`CR_LOCK];
				end
			end else if (do_one_time_area_program_cmd && in_otp) begin
				if (lock) begin
					p_err <= 1'b1;
				end else begin
					one_time_program_start <= 1'b1;
				end
			end
			// Protocol programming drags the width default along; set wins
			if (four_lane_protocol_nv_program) begin
				four_lane_width_default <= 1'b1;
			end
		end
	end

	// Registered view of the protection and lane state
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			active_protect_range <= `PROTECT_SHIPPED;
			protect_from_bottom <= 1'b0;
			param_block_at_top <= 1'b0;
			four_lane_data <= 1'b0;
			four_lane_instructions <= 1'b0;
			write_protect_active <= 1'b0;
			lock_active <= 1'b0;
			program_error <= 1'b0;
			nv_write_busy <= 1'b0;
		end else begin
			active_protect_range <= bp_sel ? protect_range_volatile : protect_range_nonvolatile;
			protect_from_bottom <= protect_start_otp;
			param_block_at_top <= param_location_otp & ~uniform_sectors;
			four_lane_data <= four_lane_width;
			four_lane_instructions <= four_lane_instruction_protocol;
			write_protect_active <= wp_low;
			lock_active <= lock;
			program_error <= p_err;
			nv_write_busy <= busy;
		end
	end

endmodule // flash_config_protection_regs

`default_nettype wire

//--- verif/flash_cfg_checker.sv
`timescale 1ns/1ns
`default_nettype none
module flash_cfg_checker #(
	parameter NV_WRITE_CYCLES = 20
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Inputs
	input wire logic [3:0] io_in,
	input wire logic lane3_reset_enable,
	input wire logic uniform_sectors,
	// State outputs
	input wire logic protect_from_bottom,
	input wire logic param_block_at_top,
	input wire logic four_lane_data,
	input wire logic write_protect_active,
	input wire logic lock_active,
	input wire logic program_error,
	input wire logic nv_write_busy,
	input wire logic one_time_program_start
);
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [3:0] since_hw;
	logic [15:0] busy_cnt;
	// Age of the last pin reset request and length of the busy run
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			since_hw <= 4'hF;
			busy_cnt <= 16'h0;
		end else begin
			if (lane3_reset_enable && !io_in[3]) since_hw <= 4'h0;
			else if (since_hw != 4'hF) since_hw <= since_hw + 4'h1;
			busy_cnt <= nv_write_busy ? busy_cnt + 16'h1 : 16'h0;
		end
	end
	property p_wp_off;
		four_lane_data [*2] |-> !write_protect_active;
	endproperty
	a_wp_off: assert property (p_wp_off) else $error("write protect live in four-lane mode");
	property p_frozen;
		lock_active [*2] |-> $stable(protect_from_bottom);
	endproperty
	a_frozen: assert property (p_frozen) else $error("option bit changed while locked");
	property p_otp_once;
		$past(protect_from_bottom) |-> protect_from_bottom;
	endproperty
	a_otp_once: assert property (p_otp_once) else $error("option bit went back to zero");
	property p_unlock;
		$fell(lock_active) |-> since_hw < 4'h8;
	endproperty
	a_unlock: assert property (p_unlock) else $error("lock cleared without pin reset");
	property p_start_open;
		one_time_program_start |-> !lock_active;
	endproperty
	a_start_open: assert property (p_start_open) else $error("one-time program started while locked");
	property p_start_pulse;
		one_time_program_start |=> !one_time_program_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("program start longer than a cycle");
	property p_err_cause;
		$rose(program_error) |-> lock_active;
	endproperty
	a_err_cause: assert property (p_err_cause) else $error("program error without lock");
	property p_uniform;
		uniform_sectors [*3] |-> !param_block_at_top;
	endproperty
	a_uniform: assert property (p_uniform) else $error("parameter block placed in uniform layout");
	property p_busy_len;
		busy_cnt <= NV_WRITE_CYCLES + 4;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("non-volatile write too long");
	c_lock: cover property ($rose(lock_active));
	c_start: cover property (one_time_program_start);
	c_busy: cover property ($rose(nv_write_busy));
endmodule // flash_cfg_checker
bind flash_config_protection_regs flash_cfg_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) flash_cfg_checker_inst (
	.core_clk, .reset_n, .io_in, .lane3_reset_enable, .uniform_sectors, .protect_from_bottom,
	.param_block_at_top, .four_lane_data, .write_protect_active, .lock_active, .program_error,
	.nv_write_busy, .one_time_program_start);
`default_nettype wire

//--- verif/spi_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
	// Clock
	input wire logic core_clk,
	// Link pins
	output logic sck,
	output logic cs_n,
	output logic si,
	// Four-lane drive, valid while qon is high
	output logic qon,
	output logic [3:0] qio,
	input wire logic [3:0] so
);
	// Link idles low, deselected
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		qon = 1'b0;
		qio = 4'hF;
	end
	// Half link period, 80 ns
	task automatic half();
		repeat (4) @(negedge core_clk);
	endtask
	// Bytes out MSB first, a bit or a nibble per clock, dummy clocks, then reads taken late in the high phase
	task automatic frame(input logic [63:0] tx, input int nb, input int dum, input int nrd, input logic q,
		output logic [7:0] rx);
		int i;
		int n;
		n = q ? nb * 2 : nb * 8;
		rx = 8'h00;
		@(negedge core_clk);
		qon = q;
		cs_n = 1'b0;
		for (i = 0; i < n + dum + nrd; i++) begin
			if (i < n && q) qio = tx[nb * 8 - 1 - 4 * i -: 4];
			else if (i < n) si = tx[nb * 8 - 1 - i];
			else si = ~si;
			half();
			sck = 1'b1;
			half();
			if (i >= n + dum) rx = q ? {rx[3:0], so} : {rx[6:0], so[1]};
			sck = 1'b0;
		end
		half();
		// Lanes are handed back in the same step as deselect, so lane 3 never looks like a reset
		cs_n = 1'b1;
		qon = 1'b0;
		si = ~si;
		repeat (6) @(negedge core_clk);
	endtask
endmodule // spi_host_model
`default_nettype wire

//--- verif/test_flash_config_protection_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_cfg_consts.vh"
module test_flash_config_protection_regs;
	logic core_clk, reset_n, proto, pgm, l3_en, uni, wp_pin, rst_pin, spare, sck, cs_n, si;
	logic [3:0] io_out, io_oe, qio;
	logic [2:0] apr, m_vp, m_np, starts, m_starts;
	logic pfb, ptop, fld, fli, wpa, lka, perr, busy, otps, m_vw, m_lock, m_perr, m_wd, qon;
	logic [7:0] m_ncf, rx;
	logic [31:0] seed;
	int bad_count, num_checks;
	flash_config_protection_regs #(.NV_WRITE_CYCLES(20)) flash_config_protection_regs_inst (
		.core_clk(core_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
		.io_in(qon ? qio : {rst_pin, wp_pin, spare, si}),
		.io_out(io_out), .io_oe(io_oe), .four_lane_instruction_protocol(proto), .four_lane_protocol_nv_program(pgm),
		.lane3_reset_enable(l3_en), .uniform_sectors(uni), .active_protect_range(apr), .protect_from_bottom(pfb),
		.param_block_at_top(ptop), .four_lane_data(fld), .four_lane_instructions(fli), .write_protect_active(wpa),
		.lock_active(lka), .program_error(perr), .nv_write_busy(busy), .one_time_program_start(otps));
	// An undriven lane shows the inverse of the last value, so a late enable is caught
	spi_host_model spi_host_model_inst (.core_clk(core_clk), .sck(sck), .cs_n(cs_n), .si(si), .qon(qon), .qio(qio),
		.so(io_out ^ ~io_oe));
	// Clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Count program start pulses
	always @(posedge core_clk) if (otps === 1'b1) starts <= starts + 3'h1;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] cfg_v();
		return (m_ncf & 8'h2C) | {6'h0, m_vw, m_lock};
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic bad(input string s);
		bad_count++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) bad($sformatf("read %h want %h", got, exp));
	endtask
	task automatic chk_st();
		logic [12:0] got, exp;
		got = {apr, lka, fld, fli, pfb, ptop, perr, wpa, starts};
		exp = {m_ncf[3] ? m_vp : m_np, m_lock, m_vw, proto, m_ncf[5], m_ncf[2] & !uni, m_perr, !m_vw & !wp_pin, m_starts};
		num_checks++;
		if (got !== exp) bad($sformatf("state %h want %h", got, exp));
	endtask
	task automatic settle();
		int n;
		n = 0;
		repeat (6) @(negedge core_clk);
		while (busy !== 1'b0) begin
			n++;
			if (n > 100) begin
				bad("busy stuck");
				end_sim();
			end
			@(negedge core_clk);
		end
	endtask
	task automatic frame(input logic [63:0] tx, input int nb);
		spi_host_model_inst.frame(tx, nb, 0, 0, proto, rx);
		settle();
	endtask
	task automatic write_registers_cmd(input logic [7:0] s, input logic [7:0] c);
		frame({40'h0, `OP_WRITE_REGS, s, c}, 3);
		// Write-disable with write-protect low refuses the whole write
		if (m_wd && !m_vw && !wp_pin) return;
		m_wd = s[7];
		if (!m_lock) begin
			if (m_ncf[3]) m_vp = s[4:2];
			else m_np = s[4:2];
			m_ncf = m_ncf | (c & 8'h2C);
		end
		if (!proto || c[1]) {m_ncf[1], m_vw} = {2{c[1]}};
		m_lock = m_lock | c[0];
	endtask
	task automatic write_any_register_cmd(input logic [23:0] a, input logic [7:0] d);
		frame({32'h0, `OP_WRITE_ANY, a, d}, 5);
		if (a == `ADDR_CONFIG_ONE_NV) begin
			if (!m_lock) m_ncf = m_ncf | (d & 8'h2C);
			if (!proto || d[1]) m_ncf[1] = d[1];
		end else begin
			if (!proto || d[1]) m_vw = d[1];
			m_lock = m_lock | d[0];
		end
	endtask
	task automatic rd(input logic [23:0] a, input logic [7:0] mask, input logic [7:0] exp);
		if (a === 24'hFFFFFF) spi_host_model_inst.frame({56'h0, `OP_READ_CONFIG}, 1, 0, proto ? 2 : 8, proto, rx);
		else spi_host_model_inst.frame({32'h0, `OP_READ_ANY, a}, 4, 0, proto ? 2 : 8, proto, rx);
		chk_rd(rx & mask, exp);
	endtask
	task automatic m_reset(input logic hw);
		m_vp = 3'h7;
		m_vw = m_ncf[1];
		m_perr = 1'b0;
		if (hw) m_lock = 1'b0;
	endtask
	// Main sequence
	initial begin
		{reset_n, proto, pgm, uni, wp_pin, spare, starts, m_starts, m_np, m_ncf, m_lock} = 24'h0;
		{l3_en, rst_pin, seed, bad_count, num_checks} = {2'h3, 32'd73, 64'h0};
		m_wd = 1'b0;
		m_reset(1'b1);
		repeat (4) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge core_clk);
		chk_st();
		@(negedge core_clk) pgm = 1'b1;
		@(negedge core_clk) pgm = 1'b0;
		m_ncf[1] = 1'b1;
		settle();
		rd(`ADDR_CONFIG_ONE_NV, 8'hFF, m_ncf & 8'h2E);
		write_registers_cmd(8'h08, 8'h00);
		chk_st();
		write_registers_cmd(8'h08, 8'h02);
		rd(24'hFFFFFF, 8'hFF, cfg_v());
		write_any_register_cmd(`ADDR_CONFIG_ONE_V, 8'h00);
		rd(`ADDR_CONFIG_ONE_NV, 8'hFF, m_ncf & 8'h2E);
		write_any_register_cmd(`ADDR_CONFIG_ONE_V, 8'h02);
		proto = 1'b1;
		write_registers_cmd(8'h08, 8'h00);
		write_any_register_cmd(`ADDR_CONFIG_ONE_V, 8'h00);
		chk_st();
		rd(`ADDR_CONFIG_ONE_NV, 8'hFF, m_ncf & 8'h2E);
		proto = 1'b0;
		$display("test four-lane done");
		write_any_register_cmd(`ADDR_CONFIG_ONE_NV, 8'hEC);
		rd(24'hFFFFFF, 8'hFF, cfg_v());
		chk_st();
		uni = 1'b1;
		write_any_register_cmd(`ADDR_CONFIG_ONE_NV, 8'h02);
		chk_st();
		uni = 1'b0;
		rd(`ADDR_CONFIG_ONE_NV, 8'hFF, m_ncf & 8'h2E);
		write_registers_cmd(8'h0C, 8'h2E);
		chk_st();
		rd(`ADDR_STATUS_ONE_NV, 8'h1C, {3'h0, m_np, 2'h0});
		$display("test options done");
		write_registers_cmd(8'h0C, 8'h2F);
		write_registers_cmd(8'h90, 8'h2C);
		chk_st();
		rd(24'hFFFFFF, 8'hFF, cfg_v());
		rd(`ADDR_STATUS_ONE_NV, 8'h9C, {m_wd, 2'h0, m_np, 2'h0});
		frame({24'h0, 8'h42, 24'h10, 8'hA5}, 5);
		m_perr = 1'b1;
		chk_st();
		frame({56'h0, 8'hF0}, 1);
		m_reset(1'b0);
		chk_st();
		rst_pin = 1'b0;
		repeat (6) @(negedge core_clk);
		rst_pin = 1'b1;
		m_reset(1'b1);
		settle();
		chk_st();
		frame({24'h0, 8'h42, 24'h10, 8'hA5}, 5);
		m_starts = 3'h1;
		chk_st();
		$display("test lock done");
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			{spare, wp_pin} = seed[5:4];
			write_registers_cmd({seed[9], 2'h0, seed[8:6], 2'h0}, {6'h0, seed[2], 1'b0});
			write_any_register_cmd(`ADDR_CONFIG_ONE_V, {6'h0, seed[1], 1'b0});
			rd(24'hFFFFFF, 8'hFF, cfg_v());
			rd(`ADDR_STATUS_ONE_NV, 8'h9C, {m_wd, 2'h0, m_np, 2'h0});
			chk_st();
		end
		$display("test random done");
		end_sim();
	end
endmodule // test_flash_config_protection_regs
`default_nettype wire
